// file: sim/pmc_testbench.sv
`timescale 1ns/1ns
module testbench;
    import pmc_pkg::*;
    // ****************************************************************
    // stimulus, observation and row table
    // ****************************************************************
    typedef struct packed {
        logic [3:0] ssel;
        logic [1:0] csel;
        logic [3:0] sper;
        logic [3:0] cper;
    } pmc_row_t;
    logic clk_i, rst_b_i, mode_req_vld_i, pll_bypass_i, pll_off_i, mult_wr_i, div_wr_i;
    logic vreg_wr_i, rtc_wake_i, reset_pin_b_i, system_clock_out_pin_en_i, relock_busy_o;
    logic core_clk_en_o, sys_clk_en_o, sys_clk_out_o, pll_enable_o, pll_bypass_o;
    logic l1_dma_allow_o, async_periph_block_o, core_power_on_o, pins_hiz_o, sys_reset_b_o;
    pmc_mode_t     mode_req_i;
    pmc_div_cfg_t  div_cfg_i;
    pmc_vreg_cfg_t vreg_cfg_i;
    logic [7:0]    mult_i, wake_en_i, wake_evt_i, pll_mult_o;
    logic [5:0]    hib_wake_i;
    logic [2:0]    mode_o;
    logic [3:0]    vreg_level_o;
    int            miscompares = 0;
    int            tests_run = 0;
    pmc_row_t      rows [4] = '{'{4'h1, 2'h1, 4'h1, 4'h2}, '{4'h2, 2'h2, 4'h2, 4'h4},
                                '{4'hf, 2'h3, 4'hf, 4'h8}, '{4'h6, 2'h0, 4'h6, 4'h1}};
    logic [7:0]    mwr [3] = '{8'h00, 8'hff, 8'h30};
    logic [7:0]    mexp [3] = '{8'h01, 8'h80, 8'h30};

    // short relock and reset-sequence counts keep the run brief
    pmc_top #(.LOCK_CYC(8), .RSEQ_CYC(4)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .mode_req_vld_i(mode_req_vld_i),
        .mode_req_i(mode_req_i), .pll_bypass_i(pll_bypass_i), .pll_off_i(pll_off_i),
        .mult_wr_i(mult_wr_i), .mult_i(mult_i), .div_wr_i(div_wr_i), .div_cfg_i(div_cfg_i),
        .vreg_wr_i(vreg_wr_i), .vreg_cfg_i(vreg_cfg_i), .wake_en_i(wake_en_i),
        .wake_evt_i(wake_evt_i), .hib_wake_i(hib_wake_i), .rtc_wake_i(rtc_wake_i),
        .reset_pin_b_i(reset_pin_b_i), .system_clock_out_pin_en_i(system_clock_out_pin_en_i), .mode_o(mode_o),
        .core_clk_en_o(core_clk_en_o), .sys_clk_en_o(sys_clk_en_o),
        .sys_clk_out_o(sys_clk_out_o), .pll_enable_o(pll_enable_o),
        .pll_bypass_o(pll_bypass_o), .pll_mult_o(pll_mult_o), .relock_busy_o(relock_busy_o),
        .l1_dma_allow_o(l1_dma_allow_o), .async_periph_block_o(async_periph_block_o),
        .core_power_on_o(core_power_on_o), .vreg_level_o(vreg_level_o),
        .pins_hiz_o(pins_hiz_o), .sys_reset_b_o(sys_reset_b_o));

    // 25 mhz clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // bounded waits; the limit stands well above any sync plus sequence delay
    task automatic wait_mode(input logic [2:0] m);
        for (int i = 0; i < 60 && mode_o !== m; i++) tick(1);
        chk(mode_o, m);
    endtask

    task automatic settle;
        for (int i = 0; i < 60 && relock_busy_o !== 1'b0; i++) tick(1);
    endtask

    // cycles between two enable pulses; 40 means no pulse at all
    task automatic period(input logic core, output int p);
        p = 0;
        for (int i = 0; i < 40 && (core ? core_clk_en_o : sys_clk_en_o) !== 1'b1; i++) tick(1);
        do begin
            tick(1);
            p++;
        end while (p < 40 && (core ? core_clk_en_o : sys_clk_en_o) !== 1'b1);
    endtask

    task automatic req(input pmc_mode_t m);
        mode_req_i = m;
        mode_req_vld_i = 1'b1;
        tick(1);
        mode_req_vld_i = 1'b0;
    endtask

    task automatic give_verdict;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // watchdog: far beyond the few hundred cycles the sequence needs
    initial begin
        #(40 * 20000);
        miscompares++;
        give_verdict();
    end

    // ****************************************************************
    // main sequence: reset, divider rows, then mode walks
    // ****************************************************************
    initial begin
        int p;
        {rst_b_i, mode_req_vld_i, pll_bypass_i, pll_off_i, mult_wr_i, div_wr_i} = '0;
        {vreg_wr_i, rtc_wake_i, system_clock_out_pin_en_i, wake_en_i, wake_evt_i, hib_wake_i} = '0;
        {mult_i, div_cfg_i, vreg_cfg_i} = '0;
        mode_req_i = PMC_FULL_ON;
        reset_pin_b_i = 1'b1;
        tick(20);
        chk({mode_o, pll_enable_o, pll_bypass_o}, {PMC_FULL_ON, 2'b10});
        chk(pll_mult_o, PMC_MULT_RST);
        chk({core_power_on_o, pins_hiz_o, l1_dma_allow_o, async_periph_block_o}, 4'ha);
        rst_b_i = 1'b1;
        settle();
        period(1'b0, p);
        chk(p, 4);
        chk(sys_clk_out_o, 1'b0);
        period(1'b1, p);
        chk(p, 1);
        system_clock_out_pin_en_i = 1'b1;
        foreach (rows[k]) begin
            div_cfg_i = {rows[k].ssel, rows[k].csel};
            div_wr_i = 1'b1;
            tick(1);
            div_wr_i = 1'b0;
            tick(1);
            chk(relock_busy_o, 1'b0);
            period(1'b0, p);
            chk(p, rows[k].sper);
            chk(sys_clk_out_o, 1'b1);
            period(1'b1, p);
            chk(p, rows[k].cper);
        end
        foreach (mwr[k]) begin
            mult_i = mwr[k];
            mult_wr_i = 1'b1;
            tick(1);
            mult_wr_i = 1'b0;
            tick(2);
            chk(pll_mult_o, mexp[k]);
            settle();
        end
        // sleep: masked wake ignored, enabled wake follows the bypass flag
        req(PMC_SLEEP);
        wait_mode(PMC_SLEEP);
        chk(l1_dma_allow_o, 1'b0);
        period(1'b0, p);
        chk(p, 6);
        period(1'b1, p);
        chk(p, 40);
        wake_evt_i = 8'h04;
        tick(8);
        chk(mode_o, PMC_SLEEP);
        wake_en_i = 8'h04;
        wait_mode(PMC_FULL_ON);
        wake_evt_i = 8'h00;
        pll_bypass_i = 1'b1;
        settle();
        // let the cleared event leave the synchroniser so it cannot wake the next sleep
        tick(3);
        req(PMC_SLEEP);
        wait_mode(PMC_SLEEP);
        tick(4);
        chk(mode_o, PMC_SLEEP);
        wake_evt_i = 8'h04;
        wait_mode(PMC_ACTIVE);
        wake_evt_i = 8'h00;
        chk(pll_bypass_o, 1'b1);
        period(1'b0, p);
        chk(p, 1);
        // pll stopped in active, then restarted before any later request
        pll_off_i = 1'b1;
        tick(2);
        chk({mode_o, pll_enable_o}, {PMC_ACTIVE, 1'b0});
        pll_off_i = 1'b0;
        tick(2);
        chk(pll_enable_o, 1'b1);
        // deep sleep: only rtc or reset pin leave it
        req(PMC_DEEP);
        wait_mode(PMC_DEEP);
        chk(async_periph_block_o, 1'b1);
        period(1'b0, p);
        chk(p, 40);
        wake_evt_i = 8'h04;
        tick(8);
        chk(mode_o, PMC_DEEP);
        wake_evt_i = 8'h00;
        rtc_wake_i = 1'b1;
        wait_mode(PMC_ACTIVE);
        rtc_wake_i = 1'b0;
        // a still-synced rtc level would pull deep sleep straight back to active
        tick(3);
        req(PMC_DEEP);
        wait_mode(PMC_DEEP);
        tick(4);
        chk(mode_o, PMC_DEEP);
        reset_pin_b_i = 1'b0;
        tick(6);
        chk(sys_reset_b_o, 1'b0);
        reset_pin_b_i = 1'b1;
        pll_bypass_i = 1'b0;
        wait_mode(PMC_FULL_ON);
        settle();
        // hibernate: only the regulator level survives the wake
        mult_i = 8'h20;
        mult_wr_i = 1'b1;
        tick(1);
        mult_wr_i = 1'b0;
        settle();
        vreg_cfg_i = {1'b1, 4'h5};
        vreg_wr_i = 1'b1;
        tick(1);
        vreg_wr_i = 1'b0;
        vreg_cfg_i = '0;
        wait_mode(PMC_HIBERNATE);
        chk({core_power_on_o, pins_hiz_o, vreg_level_o}, {2'b01, 4'h5});
        period(1'b1, p);
        chk(p, 40);
        hib_wake_i = 6'h20;
        for (int i = 0; i < 20 && sys_reset_b_o !== 1'b0; i++) tick(1);
        chk(sys_reset_b_o, 1'b0);
        hib_wake_i = 6'h00;
        wait_mode(PMC_FULL_ON);
        chk({pll_mult_o, vreg_level_o, core_power_on_o}, {PMC_MULT_RST, 4'h5, 1'b1});
        settle();
        period(1'b0, p);
        chk(p, 4);
        give_verdict();
    end
endmodule

// file: src/pmc_pkg.sv
package pmc_pkg;

    // ****************************************************************
    // operating modes of the controller
    // ****************************************************************
    typedef enum logic [2:0] {
        PMC_FULL_ON   = 3'b000,
        PMC_ACTIVE    = 3'b001,
        PMC_SLEEP     = 3'b010,
        PMC_DEEP      = 3'b011,
        PMC_HIBERNATE = 3'b100,
        PMC_RESET_SEQ = 3'b101
    } pmc_mode_t;

    // ****************************************************************
    // field widths and reset values
    // ****************************************************************
    localparam int           PMC_MULT_W    = 8;      // multiplier in half steps
    localparam int           PMC_VLEV_W    = 4;      // regulator level field
    localparam logic [7:0]   PMC_MULT_MIN  = 8'h01;  // 0.5x
    localparam logic [7:0]   PMC_MULT_MAX  = 8'h80;  // 64x
    localparam logic [7:0]   PMC_MULT_RST  = 8'h10;  // 8x
    localparam logic [3:0]   PMC_SSEL_RST  = 4'h4;   // divide by 4
    localparam logic [1:0]   PMC_CSEL_RST  = 2'h0;   // divide by 1
    localparam logic [3:0]   PMC_VLEV_RST  = 4'h8;
    localparam int           PMC_VSTEP_MV  = 50;     // regulator step size

    // ****************************************************************
    // cycle counts
    // ****************************************************************
    localparam int           PMC_LOCK_CYC  = 512;    // pll relock wait
    localparam int           PMC_RSEQ_CYC  = 16;     // reset sequence length
    localparam int           PMC_CNT_W     = 12;

    // ****************************************************************
    // grouped configuration carriers
    // ****************************************************************
    typedef struct packed {
        logic [3:0] ssel;    // system divider select
        logic [1:0] csel;    // core divider select
    } pmc_div_cfg_t;

    typedef struct packed {
        logic                  off;    // remove core power
        logic [PMC_VLEV_W-1:0] level;  // core voltage code, 50 mV per step
    } pmc_vreg_cfg_t;

endpackage

// file: src/pmc_top.sv
`timescale 1ns/1ns
module pmc_top #(
    parameter int WAKE_W   = 8,
    parameter int HWAKE_W  = 6,
    parameter int LOCK_CYC = pmc_pkg::PMC_LOCK_CYC,
    parameter int RSEQ_CYC = pmc_pkg::PMC_RSEQ_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  mode_req_vld_i,
    input  wire pmc_pkg::pmc_mode_t    mode_req_i,
    input  wire logic                  pll_bypass_i,
    input  wire logic                  pll_off_i,
    input  wire logic                  mult_wr_i,
    input  wire logic [7:0]            mult_i,
    input  wire logic                  div_wr_i,
    input  wire pmc_pkg::pmc_div_cfg_t div_cfg_i,
    input  wire logic                  vreg_wr_i,
    input  wire pmc_pkg::pmc_vreg_cfg_t vreg_cfg_i,
    input  wire logic [WAKE_W-1:0]     wake_en_i,
    input  wire logic [WAKE_W-1:0]     wake_evt_i,
    input  wire logic [HWAKE_W-1:0]    hib_wake_i,
    input  wire logic                  rtc_wake_i,
    input  wire logic                  reset_pin_b_i,
    input  wire logic                  system_clock_out_pin_en_i,
    output logic [2:0]                 mode_o,
    output logic                       core_clk_en_o,
    output logic                       sys_clk_en_o,
    output logic                       sys_clk_out_o,
    output logic                       pll_enable_o,
    output logic                       pll_bypass_o,
    output logic [7:0]                 pll_mult_o,
    output logic                       relock_busy_o,
    output logic                       l1_dma_allow_o,
    output logic                       async_periph_block_o,
    output logic                       core_power_on_o,
    output logic [3:0]                 vreg_level_o,
    output logic                       pins_hiz_o,
    output logic                       sys_reset_b_o
);
    import pmc_pkg::*;

    localparam int SYNC_W = WAKE_W + HWAKE_W + 2;
    localparam logic [PMC_CNT_W-1:0] LOCK_LD = PMC_CNT_W'(LOCK_CYC);
    localparam logic [PMC_CNT_W-1:0] RSEQ_LD = PMC_CNT_W'(RSEQ_CYC - 1);

    // ****************************************************************
    // helpers
    // ****************************************************************
    // core ratio from its 2-bit select: 1, 2, 4, 8
    function automatic logic [3:0] core_ratio(input logic [1:0] sel);
        core_ratio = 4'h1 << sel;
    endfunction

    // system ratio; a zero select would stop the clock, so it runs as 1
    function automatic logic [3:0] sys_ratio(input logic [3:0] sel);
        sys_ratio = (sel == 4'h0) ? 4'h1 : sel;
    endfunction

    // ****************************************************************
    // state
    // ****************************************************************
    pmc_mode_t             mode_r;
    logic [SYNC_W-1:0]     sync1_r;
    logic [SYNC_W-1:0]     sync2_r;
    logic [PMC_CNT_W-1:0]  seq_cnt_r;
    logic [PMC_CNT_W-1:0]  lock_cnt_r;
    logic [7:0]            mult_r;
    logic [3:0]            ssel_r;
    logic [1:0]            csel_r;
    logic [3:0]            vlev_r;
    logic [3:0]            sys_cnt_r;
    logic [3:0]            core_cnt_r;
    logic                  wake_any;
    logic                  hib_any;
    logic                  rtc_s;
    logic                  rst_pin_s;
    logic                  locking;
    logic                  cfg_ok;
    logic                  div_bypass;
    logic                  core_run;
    logic                  sys_run;
    logic                  core_tick;
    logic                  sys_tick;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    // all wake lines come from other domains or pins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= {~reset_pin_b_i, rtc_wake_i, hib_wake_i, wake_evt_i};
            sync2_r <= sync1_r;
        end
    end

    // decoded wake conditions, read from the second stage only
    assign wake_any  = |(sync2_r[WAKE_W-1:0] & wake_en_i);
    assign hib_any   = |sync2_r[WAKE_W +: HWAKE_W];
    assign rtc_s     = sync2_r[SYNC_W-2];
    assign rst_pin_s = sync2_r[SYNC_W-1];
    assign locking   = (lock_cnt_r != '0);
    // software may only reconfigure while the core is running
    assign cfg_ok    = (mode_r == PMC_FULL_ON) || (mode_r == PMC_ACTIVE);

    // ****************************************************************
    // mode sequencer
    // ****************************************************************
    // reset pin wins everywhere; it holds the reset sequence while low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_r <= PMC_FULL_ON;
        end else if (rst_pin_s) begin
            mode_r <= PMC_RESET_SEQ;
        end else begin
            unique case (mode_r)
                PMC_FULL_ON, PMC_ACTIVE: begin
                    if (vreg_wr_i && vreg_cfg_i.off) begin
                        mode_r <= PMC_HIBERNATE;
                    end else if (mode_req_vld_i) begin
                        unique case (mode_req_i)
                            PMC_ACTIVE, PMC_DEEP: begin
                                mode_r <= mode_req_i;
                            end
                            // a stopped pll cannot be relied on here
                            PMC_FULL_ON, PMC_SLEEP: begin
                                if (!(mode_r == PMC_ACTIVE && pll_off_i)) begin
                                    mode_r <= mode_req_i;
                                end
                            end
                            default: begin
                                mode_r <= mode_r;
                            end
                        endcase
                    end
                end
                PMC_SLEEP: begin
                    if (wake_any) begin
                        mode_r <= pll_bypass_i ? PMC_ACTIVE : PMC_FULL_ON;
                    end
                end
                PMC_DEEP: begin
                    if (rtc_s) begin
                        mode_r <= PMC_ACTIVE;
                    end
                end
                PMC_HIBERNATE: begin
                    if (hib_any || rtc_s) begin
                        mode_r <= PMC_RESET_SEQ;
                    end
                end
                PMC_RESET_SEQ: begin
                    if (seq_cnt_r == '0) begin
                        mode_r <= PMC_FULL_ON;
                    end
                end
                default: begin
                    mode_r <= PMC_FULL_ON;
                end
            endcase
        end
    end

    // reset sequence length, restarted while the pin is held
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seq_cnt_r <= RSEQ_LD;
        end else if (rst_pin_s || mode_r == PMC_HIBERNATE) begin
            seq_cnt_r <= RSEQ_LD;
        end else if (mode_r == PMC_RESET_SEQ && seq_cnt_r != '0) begin
            seq_cnt_r <= seq_cnt_r - 1'b1;
        end
    end

    // ****************************************************************
    // pll and divider settings
    // ****************************************************************
    // everything here is lost in hibernate and returns to defaults
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mult_r <= PMC_MULT_RST;
            ssel_r <= PMC_SSEL_RST;
            csel_r <= PMC_CSEL_RST;
        end else if (mode_r == PMC_RESET_SEQ) begin
            mult_r <= PMC_MULT_RST;
            ssel_r <= PMC_SSEL_RST;
            csel_r <= PMC_CSEL_RST;
        end else if (cfg_ok) begin
            // out-of-range multipliers are clamped, not dropped
            if (mult_wr_i) begin
                if (mult_i < PMC_MULT_MIN) begin
                    mult_r <= PMC_MULT_MIN;
                end else if (mult_i > PMC_MULT_MAX) begin
                    mult_r <= PMC_MULT_MAX;
                end else begin
                    mult_r <= mult_i;
                end
            end
            if (div_wr_i) begin
                ssel_r <= div_cfg_i.ssel;
                csel_r <= div_cfg_i.csel;
            end
        end
    end

    // relock wait after a multiplier change or a pll restart
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lock_cnt_r <= LOCK_LD;
        end else if (mode_r == PMC_RESET_SEQ || (cfg_ok && mult_wr_i)) begin
            lock_cnt_r <= LOCK_LD;
        end else if (mode_r == PMC_ACTIVE && pll_off_i) begin
            lock_cnt_r <= LOCK_LD;
        end else if (locking) begin
            lock_cnt_r <= lock_cnt_r - 1'b1;
        end
    end

    // regulator setting survives hibernate; only power-on clears it
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            vlev_r <= PMC_VLEV_RST;
        end else if (cfg_ok && vreg_wr_i) begin
            vlev_r <= vreg_cfg_i.level;
        end
    end

    // ****************************************************************
    // clock dividers
    // ****************************************************************
    // bypass: active mode, or sleep while pll_bypass_i is set
    assign div_bypass = (mode_r == PMC_ACTIVE) ||
                        (mode_r == PMC_SLEEP && pll_bypass_i);
    assign core_run   = (mode_r == PMC_ACTIVE) ||
                        (mode_r == PMC_FULL_ON && !locking);
    assign sys_run    = core_run ||
                        (mode_r == PMC_SLEEP && (div_bypass || !locking));
    assign core_tick  = div_bypass || (core_cnt_r == core_ratio(csel_r) - 4'h1);
    assign sys_tick   = div_bypass || (sys_cnt_r == sys_ratio(ssel_r) - 4'h1);

    // a divider write restarts both counters so the new ratio applies at once
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_cnt_r <= 4'h0;
            sys_cnt_r  <= 4'h0;
        end else if (div_wr_i && cfg_ok) begin
            core_cnt_r <= 4'h0;
            sys_cnt_r  <= 4'h0;
        end else begin
            core_cnt_r <= core_tick ? 4'h0 : core_cnt_r + 4'h1;
            sys_cnt_r  <= sys_tick ? 4'h0 : sys_cnt_r + 4'h1;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // enables leave flip-flops only; the gate latches them in the low phase
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_clk_en_o <= 1'b0;
            sys_clk_en_o  <= 1'b0;
            sys_clk_out_o <= 1'b0;
        end else begin
            core_clk_en_o <= core_run && core_tick;
            sys_clk_en_o  <= sys_run && sys_tick;
            sys_clk_out_o <= sys_run && sys_tick && system_clock_out_pin_en_i;
        end
    end

    // mode-dependent controls for pll, memory, supply and pads
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mode_o               <= PMC_FULL_ON;
            pll_enable_o         <= 1'b1;
            pll_bypass_o         <= 1'b0;
            pll_mult_o           <= PMC_MULT_RST;
            relock_busy_o        <= 1'b1;
            l1_dma_allow_o       <= 1'b1;
            async_periph_block_o <= 1'b0;
            core_power_on_o      <= 1'b1;
            vreg_level_o         <= PMC_VLEV_RST;
            pins_hiz_o           <= 1'b0;
            sys_reset_b_o        <= 1'b0;
        end else begin
            mode_o               <= mode_r;
            pll_enable_o         <= !(mode_r == PMC_DEEP || mode_r == PMC_HIBERNATE ||
                                      (mode_r == PMC_ACTIVE && pll_off_i));
            pll_bypass_o         <= div_bypass;
            pll_mult_o           <= mult_r;
            relock_busy_o        <= locking;
            l1_dma_allow_o       <= (mode_r != PMC_SLEEP);
            async_periph_block_o <= (mode_r == PMC_DEEP) ||
                                    (mode_r == PMC_HIBERNATE);
            core_power_on_o      <= (mode_r != PMC_HIBERNATE);
            vreg_level_o         <= vlev_r;
            pins_hiz_o           <= (mode_r == PMC_HIBERNATE);
            sys_reset_b_o        <= (mode_r != PMC_RESET_SEQ);
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_sleep_wake_full;
        mode_r == PMC_SLEEP && wake_any && !rst_pin_s && !pll_bypass_i;
    endsequence
    sequence s_hib_wake;
        mode_r == PMC_HIBERNATE && (hib_any || rtc_s) && !rst_pin_s;
    endsequence

    property p_sleep_core_off;
        mode_r == PMC_SLEEP |=> !core_clk_en_o;
    endproperty
    a_sleep_core_off: assert property (p_sleep_core_off)
        else $error("core clock enabled in sleep");

    property p_sleep_wake;
        s_sleep_wake_full |=> mode_r == PMC_FULL_ON ##1 mode_o == PMC_FULL_ON;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep wake with bypass clear did not reach full-on");

    property p_sleep_no_dma;
        mode_r == PMC_SLEEP |=> !l1_dma_allow_o;
    endproperty
    a_sleep_no_dma: assert property (p_sleep_no_dma)
        else $error("dma allowed in sleep");

    property p_deep_clocks;
        mode_r == PMC_DEEP |=> !core_clk_en_o && !sys_clk_en_o && async_periph_block_o;
    endproperty
    a_deep_clocks: assert property (p_deep_clocks)
        else $error("clock running or peripherals free in deep sleep");

    property p_deep_hold;
        mode_r == PMC_DEEP && !rtc_s && !rst_pin_s |=> mode_r == PMC_DEEP;
    endproperty
    a_deep_hold: assert property (p_deep_hold)
        else $error("deep sleep left without rtc or reset pin");

    property p_deep_rtc;
        mode_r == PMC_DEEP && rtc_s && !rst_pin_s |=> mode_r == PMC_ACTIVE;
    endproperty
    a_deep_rtc: assert property (p_deep_rtc)
        else $error("rtc did not move deep sleep to active");

    property p_hib_power;
        mode_r == PMC_HIBERNATE |=> !core_power_on_o && pins_hiz_o && !sys_clk_en_o;
    endproperty
    a_hib_power: assert property (p_hib_power)
        else $error("core power or pads active in hibernate");

    property p_hib_wake;
        s_hib_wake |=> mode_r == PMC_RESET_SEQ ##1 !sys_reset_b_o;
    endproperty
    a_hib_wake: assert property (p_hib_wake)
        else $error("hibernate wake did not start reset sequence");

    property p_vreg_kept;
        mode_r == PMC_RESET_SEQ |=> $stable(vlev_r) && ssel_r == PMC_SSEL_RST;
    endproperty
    a_vreg_kept: assert property (p_vreg_kept)
        else $error("regulator changed or divider kept across reset sequence");

    property p_mult_range;
        mult_wr_i && cfg_ok && !rst_pin_s |=> mult_r >= PMC_MULT_MIN && mult_r <= PMC_MULT_MAX
            ##1 pll_mult_o == $past(mult_r);
    endproperty
    a_mult_range: assert property (p_mult_range)
        else $error("multiplier out of range");

    property p_system_clock_out_pin_off;
        !system_clock_out_pin_en_i |=> !sys_clk_out_o;
    endproperty
    a_system_clock_out_pin_off: assert property (p_system_clock_out_pin_off)
        else $error("system clock out active while disabled");

    property p_active_bypass;
        mode_r == PMC_ACTIVE |=> pll_bypass_o && core_clk_en_o && sys_clk_en_o;
    endproperty
    a_active_bypass: assert property (p_active_bypass)
        else $error("active mode not at input clock rate");

endmodule
